// ==== dpt_pkg.sv ====
package dpt_pkg;

	// Clock and nonvolatile write timing
	localparam int CORE_CLK_HZ = 20_000_000;
	localparam int NV_WRITE_TYP_MS = 5;
	localparam int NV_WRITE_MAX_MS = 10;
	localparam int NV_WRITE_CYCLES_DFLT = (CORE_CLK_HZ / 1000) * NV_WRITE_TYP_MS;
	localparam int NV_WRITE_CYCLES_MAX = (CORE_CLK_HZ / 1000) * NV_WRITE_MAX_MS;
	localparam int NV_CNT_W = 18;

	// Serial framing
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam int ADDR_TYPE_MSB = 7;
	localparam int ADDR_TYPE_LSB = 4;
	localparam int ADDR_STRAP_HIGH_POS = 3;
	localparam int ADDR_STRAP_MID_POS = 2;
	localparam int ADDR_STRAP_LOW_POS = 0;
	localparam int INSTR_OP_MSB = 7;
	localparam int INSTR_OP_LSB = 4;
	localparam int INSTR_SEL_HI_POS = 3;
	localparam int INSTR_SEL_LO_POS = 2;

	// Register geometry and reset values
	localparam int WIPER_W = 6;
	localparam int TAP_COUNT = 64;
	localparam int NUM_STORED = 4;
	localparam logic [5:0] STORED_RESET = 6'h00;
	localparam logic [5:0] WIPER_TOP = 6'h3F;
	localparam logic [5:0] WIPER_BOTTOM = 6'h00;

	// Command record passed through the FIFO
	localparam int REC_W = 12;
	localparam int REC_OP_LSB = 8;
	localparam int REC_SEL_LSB = 6;
	localparam int REC_DATA_LSB = 0;
	localparam int FIFO_DEPTH = 16;

	// Instruction opcodes
	typedef enum logic [3:0] {
		OP_RD_WIPER = 4'h9,
		OP_WR_WIPER = 4'hA,
		OP_RD_DATA = 4'hB,
		OP_WR_DATA = 4'hC,
		OP_DATA_TO_WIPER = 4'hD,
		OP_WIPER_TO_DATA = 4'hE,
		OP_INC_DEC = 4'h2
	} dpt_op_type;

	// Serial front end states, Gray along the usual path
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_INSTR = 3'h3,
		ST_DATA = 3'h2,
		ST_SEND = 3'h6,
		ST_INC_DEC = 3'h7,
		ST_IGNORE = 3'h5
	} dpt_state_type;

endpackage

// ==== dpt_fifo.sv ====
module dpt_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_ff;
	logic [AW:0] rd_ptr_ff;
	logic push;
	logic pop;

	// Extra pointer bit tells full from empty
	assign in_ready = !((wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
		(wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]));
	assign out_valid = (wr_ptr_ff != rd_ptr_ff);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr_ff[AW-1:0]];

	// Storage, no reset needed on data
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr_ff[AW-1:0]] <= in_data;
		end
	end

	// Write pointer
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			wr_ptr_ff <= '0;
		end else if (push) begin
			wr_ptr_ff <= wr_ptr_ff + 1'b1;
		end
	end

	// Read pointer
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rd_ptr_ff <= '0;
		end else if (pop) begin
			rd_ptr_ff <= rd_ptr_ff + 1'b1;
		end
	end

endmodule

// ==== dpt_tap_decode.sv ====
module dpt_tap_decode
	import dpt_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [WIPER_W-1:0] position,
	output logic [TAP_COUNT-1:0] tap_select
);
	logic [TAP_COUNT-1:0] nxt_tap_ff;
	logic [TAP_COUNT-1:0] tap_ff;

	// Exactly one switch closed for any position
	always_comb begin
		nxt_tap_ff = '0;
		nxt_tap_ff[position] = 1'b1;
	end

	// Registered so no decode glitch reaches two switches at once
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			tap_ff <= {{(TAP_COUNT-1){1'b0}}, 1'b1};
		end else begin
			tap_ff <= nxt_tap_ff;
		end
	end

	assign tap_select = tap_ff;

endmodule

// ==== dpt_slave.sv ====
// Behaviour
// - Every bit in or out is timed by the master's serial clock.
// - Data line only pulled low or released, never driven high.
// - Three strap pins give address bits 3, 2 and 0 of the slave address.
// - Write-protect low blocks every nonvolatile stored-register write.
// - Data changes only with clock low; high-clock changes are start or stop.
// - Falling data with clock high is start; ignore everything before a start.
// - Rising data with clock high is stop and ends the communication.
// - Transmitter releases after eight bits; receiver pulls low on ninth clock.
// - Acknowledge matching address, a command byte with a listed opcode, and a following data byte.
// - Six-bit wiper decodes one-hot onto sixty-four taps, only one on.
// - Wiper loads by direct write or from a stored register; all readable.
// - Upper address nibble must equal the fixed device type nibble.
// - All three strap bits must match exactly, otherwise no acknowledge.
// - Stop after a nonvolatile write starts the internal write; inputs disabled.
// - Address acknowledge withheld while internal write busy, given once finished.
// - Byte after address is instruction: opcode nibble plus register select.
// - After increment/decrement ack, clock pulses step wiper by data level.
// - Stored-register changes are nonvolatile and finish within ten milliseconds.
// - Opcodes 9,A,B,C,D,E and 2 decode to the seven operations.
module dpt_slave
	import dpt_pkg::*;
#(
	parameter logic [3:0] DEV_TYPE_ID = 4'hA, // Arbitrary neutral value
	parameter int NV_WRITE_CYCLES = NV_WRITE_CYCLES_DFLT
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic strap_addr_bit_low,
	input wire logic strap_addr_bit_mid,
	input wire logic strap_addr_bit_high,
	input wire logic write_protect_b,
	output logic [WIPER_W-1:0] wiper_position_reg,
	output logic [TAP_COUNT-1:0] tap_select,
	output logic nv_busy
);
	logic scl_q_ff;
	logic sda_q_ff;
	logic start_det;
	logic stop_det;
	logic scl_rise;
	logic scl_fall;
	dpt_state_type state_ff;
	logic [3:0] bit_cnt_ff;
	logic [7:0] shift_ff;
	logic [7:0] tx_ff;
	logic pull_low_ff;
	logic ack_slot_ff;
	dpt_op_type op_ff;
	logic [1:0] sel_ff;
	logic pend_ff;
	logic [REC_W-1:0] pend_rec_ff;
	logic rec_valid;
	logic [REC_W-1:0] rec_data;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [REC_W-1:0] fifo_out_data;
	logic [WIPER_W-1:0] wiper_ff;
	logic [WIPER_W-1:0] stored_ff [NUM_STORED];
	logic busy_ff;
	logic [NV_CNT_W-1:0] busy_cnt_ff;
	logic [1:0] nv_sel_ff;
	logic [WIPER_W-1:0] nv_data_ff;
	logic addr_match;
	logic byte_done;
	logic op_known;
	logic [WIPER_W-1:0] read_value;
	dpt_op_type pop_op;
	logic [1:0] pop_sel;
	logic [WIPER_W-1:0] pop_data;

	// Previous line levels for condition and edge detection
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
		end else begin
			scl_q_ff <= scl_in;
			sda_q_ff <= sda_in;
		end
	end

	// Start and stop are data edges under a high clock
	assign start_det = scl_in && scl_q_ff && sda_q_ff && !sda_in;
	assign stop_det = scl_in && scl_q_ff && !sda_q_ff && sda_in;
	assign scl_rise = scl_in && !scl_q_ff;
	assign scl_fall = !scl_in && scl_q_ff;
	assign byte_done = scl_fall && (bit_cnt_ff == BITS_PER_BYTE) && !ack_slot_ff &&
		state_ff != ST_INC_DEC; // Step pulses never open an ack slot

	// Address compare; bit 1 has no strap pin and is not looked at
	assign addr_match = (shift_ff[ADDR_TYPE_MSB:ADDR_TYPE_LSB] == DEV_TYPE_ID) &&
		(shift_ff[ADDR_STRAP_HIGH_POS] == strap_addr_bit_high) &&
		(shift_ff[ADDR_STRAP_MID_POS] == strap_addr_bit_mid) &&
		(shift_ff[ADDR_STRAP_LOW_POS] == strap_addr_bit_low);

	// Only the seven listed opcodes are acknowledged
	always_comb begin
		case (shift_ff[INSTR_OP_MSB:INSTR_OP_LSB])
			OP_RD_WIPER, OP_WR_WIPER, OP_RD_DATA, OP_WR_DATA,
			OP_DATA_TO_WIPER, OP_WIPER_TO_DATA, OP_INC_DEC: op_known = 1'b1;
			default: op_known = 1'b0;
		endcase
	end

	// Value returned by a read instruction
	always_comb begin
		if (shift_ff[INSTR_OP_MSB:INSTR_OP_LSB] == OP_RD_WIPER) begin
			read_value = wiper_ff;
		end else begin
			read_value = stored_ff[{shift_ff[INSTR_SEL_HI_POS], shift_ff[INSTR_SEL_LO_POS]}];
		end
	end

	// Bit counter: rises count bits, the ninth rise (in the ack slot) restarts it at zero
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			bit_cnt_ff <= 4'h0;
		end else if (start_det || stop_det) begin
			bit_cnt_ff <= 4'h0;
		end else if (scl_rise && state_ff != ST_IDLE &&
			(state_ff != ST_IGNORE || ack_slot_ff)) begin // Last ack slot still closes
			if (ack_slot_ff) begin
				bit_cnt_ff <= 4'h0;
			end else if (bit_cnt_ff != BITS_PER_BYTE) begin
				bit_cnt_ff <= bit_cnt_ff + 4'h1;
			end
		end
	end

	// Receive shifter, MSB first, sampled on the rising clock
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			shift_ff <= 8'h00;
		end else if (scl_rise && !ack_slot_ff && bit_cnt_ff != BITS_PER_BYTE) begin
			shift_ff <= {shift_ff[6:0], sda_in};
		end
	end

	// Ack slot marker: set after the eighth bit, cleared when ninth clock falls
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ack_slot_ff <= 1'b0;
		end else if (start_det || stop_det) begin
			ack_slot_ff <= 1'b0;
		end else if (byte_done && state_ff != ST_IDLE && state_ff != ST_IGNORE) begin
			ack_slot_ff <= 1'b1;
		end else if (scl_fall && ack_slot_ff && bit_cnt_ff == 4'h0) begin
			ack_slot_ff <= 1'b0;
		end
	end

	// Protocol sequencer; all line changes happen on a falling clock
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state_ff <= ST_IDLE;
		end else if (start_det) begin
			state_ff <= ST_ADDR;
		end else if (stop_det) begin
			state_ff <= ST_IDLE;
		end else if (byte_done) begin
			case (state_ff)
				ST_ADDR: begin
					// Busy write or full queue looks like an absent device
					if (addr_match && !busy_ff && fifo_in_ready) begin
						state_ff <= ST_INSTR;
					end else begin
						state_ff <= ST_IGNORE;
					end
				end
				ST_INSTR: begin
					case (shift_ff[INSTR_OP_MSB:INSTR_OP_LSB])
						OP_RD_WIPER, OP_RD_DATA: state_ff <= ST_SEND;
						OP_WR_WIPER, OP_WR_DATA: state_ff <= ST_DATA;
						OP_INC_DEC: state_ff <= ST_INC_DEC;
						default: state_ff <= ST_IGNORE;
					endcase
				end
				ST_DATA: state_ff <= ST_IGNORE;
				ST_SEND: state_ff <= ST_IGNORE;
				default: state_ff <= state_ff;
			endcase
		end
	end

	// Latched instruction fields
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			op_ff <= OP_RD_WIPER;
			sel_ff <= 2'h0;
		end else if (byte_done && state_ff == ST_INSTR) begin
			op_ff <= dpt_op_type'(shift_ff[INSTR_OP_MSB:INSTR_OP_LSB]);
			sel_ff <= {shift_ff[INSTR_SEL_HI_POS], shift_ff[INSTR_SEL_LO_POS]};
		end
	end

	// Transmit byte loaded when the instruction is taken
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			tx_ff <= 8'h00;
		end else if (byte_done && state_ff == ST_INSTR) begin
			tx_ff <= {2'h0, read_value};
		end else if (state_ff == ST_SEND && scl_fall && !ack_slot_ff) begin
			tx_ff <= {tx_ff[6:0], 1'b0};
		end
	end

	// Open-drain driver: pull for ack or a zero data bit, else release
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			pull_low_ff <= 1'b0;
		end else if (start_det || stop_det) begin
			pull_low_ff <= 1'b0;
		end else if (byte_done) begin
			case (state_ff)
				ST_ADDR: pull_low_ff <= addr_match && !busy_ff && fifo_in_ready;
				ST_INSTR: pull_low_ff <= op_known;
				ST_DATA: pull_low_ff <= 1'b1;
				default: pull_low_ff <= 1'b0;
			endcase
		end else if (scl_fall && ack_slot_ff && bit_cnt_ff == 4'h0) begin
			// End of ack slot: first read bit goes out on the same fall
			pull_low_ff <= (state_ff == ST_SEND) && !tx_ff[7];
		end else if (scl_fall && state_ff == ST_SEND && !ack_slot_ff) begin
			pull_low_ff <= !tx_ff[6];
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = pull_low_ff;

	// Nonvolatile command held until the stop that ends it
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			pend_ff <= 1'b0;
			pend_rec_ff <= '0;
		end else if (start_det || stop_det) begin
			pend_ff <= 1'b0;
		end else if (byte_done && state_ff == ST_INSTR &&
			shift_ff[INSTR_OP_MSB:INSTR_OP_LSB] == OP_WIPER_TO_DATA) begin
			pend_ff <= 1'b1;
			pend_rec_ff <= {OP_WIPER_TO_DATA,
				shift_ff[INSTR_SEL_HI_POS], shift_ff[INSTR_SEL_LO_POS], 6'h00};
		end else if (byte_done && state_ff == ST_DATA && op_ff == OP_WR_DATA) begin
			pend_ff <= 1'b1;
			pend_rec_ff <= {OP_WR_DATA, sel_ff, shift_ff[5:0]};
		end
	end

	// Records entering the queue; the address ack promised room for one
	always_comb begin
		rec_valid = 1'b0;
		rec_data = '0;
		if (stop_det && pend_ff) begin
			rec_valid = 1'b1;
			rec_data = pend_rec_ff;
		end else if (byte_done && state_ff == ST_INSTR &&
			shift_ff[INSTR_OP_MSB:INSTR_OP_LSB] == OP_DATA_TO_WIPER) begin
			rec_valid = 1'b1;
			rec_data = {OP_DATA_TO_WIPER,
				shift_ff[INSTR_SEL_HI_POS], shift_ff[INSTR_SEL_LO_POS], 6'h00};
		end else if (byte_done && state_ff == ST_DATA && op_ff == OP_WR_WIPER) begin
			rec_valid = 1'b1;
			rec_data = {OP_WR_WIPER, sel_ff, shift_ff[5:0]};
		end else if (scl_rise && state_ff == ST_INC_DEC && !ack_slot_ff) begin
			// One step per clock pulse; steps beyond a full queue are lost
			rec_valid = 1'b1;
			rec_data = {OP_INC_DEC, sel_ff, 5'h00, sda_in};
		end
	end

	dpt_fifo #(
		.WIDTH(REC_W),
		.DEPTH(FIFO_DEPTH)
	) u_cmd_fifo (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.in_valid(rec_valid),
		.in_ready(fifo_in_ready),
		.in_data(rec_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// Engine drains only while no internal write runs
	assign fifo_out_ready = !busy_ff;
	assign pop_op = dpt_op_type'(fifo_out_data[REC_OP_LSB+3:REC_OP_LSB]);
	assign pop_sel = fifo_out_data[REC_SEL_LSB+1:REC_SEL_LSB];
	assign pop_data = fifo_out_data[REC_DATA_LSB+WIPER_W-1:REC_DATA_LSB];

	// Wiper register; power-up value mirrors stored setting zero
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			wiper_ff <= STORED_RESET;
		end else if (fifo_out_valid && fifo_out_ready) begin
			case (pop_op)
				OP_WR_WIPER: wiper_ff <= pop_data;
				OP_DATA_TO_WIPER: wiper_ff <= stored_ff[pop_sel];
				OP_INC_DEC: begin
					// Saturates at either end of the array
					if (pop_data[0] && wiper_ff != WIPER_TOP) begin
						wiper_ff <= wiper_ff + 6'h01;
					end else if (!pop_data[0] && wiper_ff != WIPER_BOTTOM) begin
						wiper_ff <= wiper_ff - 6'h01;
					end
				end
				default: wiper_ff <= wiper_ff;
			endcase
		end
	end

	// Internal nonvolatile write timer
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			busy_ff <= 1'b0;
			busy_cnt_ff <= '0;
			nv_sel_ff <= 2'h0;
			nv_data_ff <= '0;
		end else if (busy_ff) begin
			if (busy_cnt_ff == NV_CNT_W'(NV_WRITE_CYCLES - 1)) begin
				busy_ff <= 1'b0;
			end else begin
				busy_cnt_ff <= busy_cnt_ff + 1'b1;
			end
		end else if (fifo_out_valid && write_protect_b &&
			(pop_op == OP_WR_DATA || pop_op == OP_WIPER_TO_DATA)) begin
			busy_ff <= 1'b1;
			busy_cnt_ff <= '0;
			nv_sel_ff <= pop_sel;
			nv_data_ff <= (pop_op == OP_WR_DATA) ? pop_data : wiper_ff;
		end
	end

	// Stored registers commit when the write time has elapsed
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_STORED; i++) begin
				stored_ff[i] <= STORED_RESET;
			end
		end else if (busy_ff && busy_cnt_ff == NV_CNT_W'(NV_WRITE_CYCLES - 1)) begin
			stored_ff[nv_sel_ff] <= nv_data_ff;
		end
	end

	dpt_tap_decode u_tap_decode (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.position(wiper_ff),
		.tap_select(tap_select)
	);

	assign wiper_position_reg = wiper_ff;
	assign nv_busy = busy_ff;

endmodule

// ==== dpt_slave_checker.sv ====
module dpt_slave_checker
	import dpt_pkg::*;
#(
	parameter logic [3:0] DEV_TYPE_ID = 4'hA,
	parameter int NV_WRITE_CYCLES = NV_WRITE_CYCLES_DFLT
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic strap_addr_bit_low,
	input wire logic strap_addr_bit_mid,
	input wire logic strap_addr_bit_high,
	input wire logic write_protect_b,
	input wire logic [WIPER_W-1:0] wiper_position_reg,
	input wire logic [TAP_COUNT-1:0] tap_select,
	input wire logic nv_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	int busy_cnt_ff;

	// Busy length, cleared while the write engine idles
	always_ff @(posedge core_clk) begin
		if (!rst_b || !nv_busy) begin
			busy_cnt_ff <= 0;
		end else begin
			busy_cnt_ff <= busy_cnt_ff + 1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// Tap switches and output pin
	AST_TAP_ONEHOT: assert property ($onehot(tap_select))
		else $error("tap select not one-hot");
	AST_TAP_FOLLOWS: assert property (tap_select == (64'h1 << $past(wiper_position_reg)))
		else $error("tap select does not follow wiper");
	AST_SDA_CONST: assert property (sda_out == 1'b0)
		else $error("data pin driven high");
	// Pull only moves while the bus clock is low, just after its fall
	AST_OE_HIGH_STABLE: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
		else $error("data pull changed with clock high");
	AST_OE_TIMING: assert property ($changed(sda_oe) |->
		!$past(scl_in) && ($past(scl_in, 2) || $past(scl_in, 3)))
		else $error("data pull moved off the clock fall");
	// Internal write: silent on the bus, exact length, write protect
	AST_BUSY_QUIET: assert property (nv_busy |-> !sda_oe)
		else $error("acknowledge while busy");
	AST_BUSY_LEN: assert property ($fell(nv_busy) |-> busy_cnt_ff == NV_WRITE_CYCLES)
		else $error("internal write length wrong");
	AST_WP_BLOCKS: assert property ($rose(nv_busy) |-> $past(write_protect_b))
		else $error("write started while protected");

	cover property ($rose(sda_oe));
	cover property ($fell(nv_busy));
	cover property (wiper_position_reg == WIPER_TOP);
endmodule

bind dpt_slave dpt_slave_checker #(.DEV_TYPE_ID(DEV_TYPE_ID), .NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_chk (
	.core_clk, .rst_b, .scl_in, .sda_in, .sda_out, .sda_oe, .strap_addr_bit_low,
	.strap_addr_bit_mid, .strap_addr_bit_high, .write_protect_b, .wiper_position_reg,
	.tap_select, .nv_busy);

// ==== dpt_master_model.sv ====
module dpt_master_model (
	input wire logic core_clk,
	output logic scl_out,
	output logic sda_drv,
	input wire logic sda_line
);
	timeunit 1ns;
	timeprecision 1ns;
	int hp = 3; // Half bit in core cycles; raise for a slow master

	// Both lines released at power-up
	initial begin
		scl_out = 1'b1;
		sda_drv = 1'b1;
	end

	// Every change lands the same skew after a core edge
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#5;
	endtask

	// Data released before the clock rises, so a late ack cannot fake a stop
	task automatic bus_start();
		sda_drv = 1'b1;
		tick(hp);
		scl_out = 1'b1;
		tick(hp);
		sda_drv = 1'b0;
		tick(hp);
		scl_out = 1'b0;
		tick(1);
	endtask

	task automatic bus_stop();
		sda_drv = 1'b0;
		tick(hp);
		scl_out = 1'b1;
		tick(hp);
		sda_drv = 1'b1;
		tick(hp);
	endtask

	// Data set with the clock low, line sampled at the end of the high phase
	task automatic bit_cyc(input logic b, output logic r);
		sda_drv = b;
		tick(hp);
		scl_out = 1'b1;
		tick(hp);
		r = sda_line;
		scl_out = 1'b0;
		tick(1);
	endtask

	task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_cyc(d[i], r[i]);
		end
		bit_cyc(1'b1, a);
		ack = ~a;
	endtask

	// Wiper step pulses, data level gives the direction
	task automatic pulses(input logic up, input int n);
		logic r;
		repeat (n) bit_cyc(up, r);
	endtask
endmodule

// ==== tb_top.sv ====
module tb_top
	import dpt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [3:0] DEV_ID = 4'hA; // Arbitrary type nibble
	localparam logic [7:0] ADDR = {DEV_ID, 4'h9};
	localparam int NV_CYC = 300; // Long enough to be polled at least once
	typedef struct packed {
		logic wp;
		logic [7:0] instr;
		logic [7:0] data;
		logic [1:0] kind;
		logic [7:0] rd;
		logic [5:0] wip;
	} dpt_row_type;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic wp_b = 1'b1;
	logic [2:0] strap = 3'h5;
	logic scl, sda_m, sda_out, sda_oe, nv_busy, ack;
	logic [7:0] rd;
	logic [WIPER_W-1:0] wiper;
	logic [TAP_COUNT-1:0] taps;
	wire logic sda_line;
	int error_cnt = 0;
	int checked = 0;
	int nacks;
	// Kind 0 two bytes, 1 write, 2 read; expected read byte and wiper after
	// Instruction bytes keep their two low bits at zero
	dpt_row_type rows [11] = '{
		'{1'b1, 8'hA0, 8'h15, 2'h1, 8'h00, 6'h15},
		'{1'b1, 8'h90, 8'h00, 2'h2, 8'h15, 6'h15},
		'{1'b1, 8'hC4, 8'h2A, 2'h1, 8'h00, 6'h15},
		'{1'b1, 8'hB4, 8'h00, 2'h2, 8'h2A, 6'h15},
		'{1'b1, 8'hD4, 8'h00, 2'h0, 8'h00, 6'h2A},
		'{1'b1, 8'hA0, 8'h3F, 2'h1, 8'h00, 6'h3F},
		'{1'b1, 8'hE8, 8'h00, 2'h0, 8'h00, 6'h3F},
		'{1'b1, 8'hB8, 8'h00, 2'h2, 8'h3F, 6'h3F},
		'{1'b1, 8'hD0, 8'h00, 2'h0, 8'h00, 6'h00},
		'{1'b0, 8'hC4, 8'h11, 2'h1, 8'h00, 6'h00},
		'{1'b1, 8'hB4, 8'h00, 2'h2, 8'h2A, 6'h00}
	};
	// Straps, expected ack, address byte
	logic [11:0] addr_rows [8] = '{12'hBA9, 12'hBAB, 12'hAA1, 12'hAAD, 12'hAA8, 12'hA59,
		12'h5A4, 12'h4A9};

	assign sda_line = sda_m & ~sda_oe; // Pull-up, either party may pull low
	always #25 core_clk = ~core_clk;

	dpt_master_model MST (.core_clk(core_clk), .scl_out(scl), .sda_drv(sda_m), .sda_line(sda_line));
	dpt_slave #(.DEV_TYPE_ID(DEV_ID), .NV_WRITE_CYCLES(NV_CYC)) DUT (
		.core_clk(core_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe(sda_oe), .strap_addr_bit_low(strap[0]), .strap_addr_bit_mid(strap[1]),
		.strap_addr_bit_high(strap[2]), .write_protect_b(wp_b), .wiper_position_reg(wiper),
		.tap_select(taps), .nv_busy(nv_busy));

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (error_cnt == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Poll with the address until answered; returns the refusals seen
	task automatic poll(output int n);
		n = 0;
		repeat (20) begin
			MST.bus_start();
			MST.xfer(ADDR, rd, ack);
			MST.bus_stop();
			if (ack) return;
			n++;
		end
		chk(1'b0, 1'b1);
	endtask

	// Cut a hang short; the run needs far less than this
	initial begin
		#(50 * 60000);
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		repeat (4) @(posedge core_clk);
		#5;
		rst_b = 1'b1;
		@(posedge core_clk);
		#5;
		chk(taps, 64'h1);
		chk({nv_busy, sda_oe, wiper}, 8'h00);
		chk(sda_out, 1'b0);
		// A byte clocked in without a start is ignored
		MST.xfer(ADDR, rd, ack);
		chk(ack, 1'b0);
		foreach (rows[i]) begin
			MST.hp = (i < 6) ? 3 : 6; // Later rows run a slow master
			wp_b = rows[i].wp;
			MST.bus_start();
			MST.xfer(ADDR, rd, ack);
			chk(ack, 1'b1);
			MST.xfer(rows[i].instr, rd, ack);
			chk(ack, 1'b1);
			if (rows[i].kind == 2'h1) begin
				MST.xfer(rows[i].data, rd, ack);
				chk(ack, 1'b1);
			end
			if (rows[i].kind == 2'h2) begin
				MST.xfer(8'hFF, rd, ack);
				chk(rd, rows[i].rd);
			end
			MST.bus_stop();
			poll(nacks);
			chk(nacks != 0, rows[i].wp && (rows[i].instr[7:4] inside {4'hC, 4'hE}));
			chk(wiper, rows[i].wip);
			chk(taps, 64'h1 << rows[i].wip);
		end
		// Address compare, refused addresses stay silent to the end
		MST.hp = 3;
		wp_b = 1'b1;
		foreach (addr_rows[i]) begin
			strap = addr_rows[i][11:9];
			MST.bus_start();
			MST.xfer(addr_rows[i][7:0], rd, ack);
			chk(ack, addr_rows[i][8]);
			MST.xfer(8'hA0, rd, ack);
			chk(ack, addr_rows[i][8]);
			MST.bus_stop();
		end
		strap = 3'h5;
		// Step mode, saturating at the top
		MST.bus_start();
		MST.xfer(ADDR, rd, ack);
		MST.xfer(8'hA0, rd, ack);
		MST.xfer(8'h3E, rd, ack);
		MST.bus_stop();
		MST.bus_start();
		MST.xfer(ADDR, rd, ack);
		MST.xfer(8'h20, rd, ack);
		chk(ack, 1'b1);
		MST.pulses(1'b1, 3);
		repeat (4) @(posedge core_clk);
		#5;
		chk(wiper, 6'h3F);
		MST.pulses(1'b0, 2);
		repeat (4) @(posedge core_clk);
		#5;
		chk(wiper, 6'h3D);
		chk(taps, 64'h1 << 6'h3D);
		// Run past eight pulses: no step may be swallowed by a byte boundary
		MST.pulses(1'b0, 8);
		repeat (4) @(posedge core_clk);
		#5;
		chk(wiper, 6'h35);
		MST.bus_stop();
		tally_and_finish();
	end
endmodule
